// ==== hw/adcs_decim_filter.sv ====
/*
  Decimation filter: counts ones of the modulator bitstream over one
  conversion and scales the count to a signed 12-bit code.
  Assumes bit_in is already synchronised and tick_in is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module adcs_decim_filter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic finish_in,
  input wire logic bit_in,
  input wire logic [10:0] ticks_in,
  input wire logic [16:0] recip_in,
  // result
  output logic [11:0] code_out,
  output logic done_out
);

  typedef struct packed {
    logic [10:0] acc;
    logic [11:0] code;
    logic done;
  } adcs_filt_t;

  adcs_filt_t q;
  adcs_filt_t next_q;
  logic [10:0] total;
  logic signed [12:0] diff;
  logic signed [30:0] prod;
  logic signed [30:0] scaled;
  logic [11:0] sat;

  // code = (2*ones - n) * 2048 / n, the reciprocal avoids a divider
  assign total = q.acc + 11'(bit_in);
  assign diff = $signed({1'b0, total, 1'b0}) - $signed({2'b00, ticks_in});
  assign prod = diff * $signed({1'b0, recip_in});
  assign scaled = prod >>> adcs_pkg::CODE_SHIFT;

  // all-ones input would give +2048, but the truncated reciprocal lands it on 2047; clamp to the code range anyway
  always_comb begin
    if (int'(scaled) > adcs_pkg::CODE_MAX) begin
      sat = 12'h7ff;
    end else if (int'(scaled) < adcs_pkg::CODE_MIN) begin
      sat = 12'h800;
    end else begin
      sat = scaled[11:0];
    end
  end

  // integrate and dump
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (clear_in) begin
      next_q.acc = 11'h000;
    end else if (tick_in) begin
      if (finish_in) begin
        next_q.code = sat;
        next_q.done = 1'b1;
        next_q.acc = 11'h000; // next conversion starts without a gap
      end else begin
        next_q.acc = total;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign code_out = q.code;
  assign done_out = q.done;

  a_done_finish: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_in && finish_in && !clear_in) |=> done_out)
    else $error("filter missed end of conversion");

  a_done_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    done_out |-> $past(tick_in && finish_in && !clear_in))
    else $error("filter done without end of conversion");

  a_full_scale: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_in && finish_in && !clear_in && total == ticks_in) |=> code_out == 12'h7ff)
    else $error("full-scale bitstream did not give top code");

endmodule : adcs_decim_filter

`default_nettype wire

// ==== hw/adcs_mod_clock.sv ====
/*
  Modulator rate divider: makes the 1 MHz oscillator enable from the
  system clock, then divides it by four into a one-cycle modulator tick.
  Assumes en_in comes from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module adcs_mod_clock #(
  parameter int unsigned OSC_DIV = adcs_pkg::CLK_PER_OSC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic en_in,
  // modulator tick
  output logic mod_tick_out
);

  localparam int MOD_PERIOD = int'(OSC_DIV) * int'(adcs_pkg::MOD_DIV);

  typedef struct packed {
    logic [7:0] pre;
    logic [1:0] quarter;
    logic tick;
  } adcs_div_t;

  adcs_div_t q;
  adcs_div_t next_q;

  // prescaler to the oscillator rate, then a divide by four
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (!en_in) begin
      next_q.pre = 8'h00; // restart phase so a fresh conversion starts aligned
      next_q.quarter = 2'h0;
    end else if (q.pre == 8'(OSC_DIV - 1)) begin
      next_q.pre = 8'h00;
      if (q.quarter == 2'(adcs_pkg::MOD_DIV - 1)) begin
        next_q.quarter = 2'h0;
        next_q.tick = 1'b1;
      end else begin
        next_q.quarter = q.quarter + 2'h1;
      end
    end else begin
      next_q.pre = q.pre + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign mod_tick_out = q.tick;

  // tick spacing while enabled equals the oscillator period times four
  a_mod_period: assert property (@(posedge clk_in) disable iff (rst_in || !en_in)
    mod_tick_out |-> ##[MOD_PERIOD:MOD_PERIOD] mod_tick_out)
    else $error("modulator tick period wrong");

  a_mod_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !en_in |=> !mod_tick_out)
    else $error("modulator tick while disabled");

endmodule : adcs_mod_clock

`default_nettype wire

// ==== hw/adcs_pkg.sv ====
/*
  Shared constants, types and lookup functions for the conversion
  sequencer, its modulator clock divider and its decimation filter.
  Assumes a single 40 MHz system clock; all rates are derived from it.
*/
`default_nettype none

package adcs_pkg;

  // clocking: system clock, internal oscillator and modulator division
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;
  localparam int unsigned MOD_DIV = 4;
  localparam int unsigned CLK_PER_OSC = CLK_HZ / OSC_HZ;
  localparam int unsigned MOD_HZ = OSC_HZ / MOD_DIV;

  // widths of the result, the per-conversion tick count and the scale factor
  localparam int unsigned CODE_W = 12;
  localparam int unsigned TICK_W = 11;
  localparam int unsigned RECIP_W = 17;
  localparam int unsigned RECIP_SHIFT = 22;
  localparam int unsigned CODE_SHIFT = 11;
  localparam int CODE_MAX = 2047;
  localparam int CODE_MIN = -2048;

  // output data rates in samples per second, indexed by the rate field
  localparam int unsigned RATE_SPS [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};

  // input selector codes; bit 2 set means single-ended against ground
  localparam logic [2:0] SEL_P0_N1 = 3'h0;
  localparam logic [2:0] SEL_P0_N3 = 3'h1;
  localparam logic [2:0] SEL_P1_N3 = 3'h2;
  localparam logic [2:0] SEL_P2_N3 = 3'h3;
  localparam logic [2:0] SEL_SE_P0 = 3'h4;
  localparam logic [2:0] SEL_SE_P1 = 3'h5;
  localparam logic [2:0] SEL_SE_P2 = 3'h6;
  localparam logic [2:0] SEL_SE_P3 = 3'h7;
  localparam int unsigned SEL_SE_BIT = 2;

  // one-hot switch sets for the four analog inputs, plus the empty set IN_NONE
  localparam logic [3:0] IN_NONE = 4'h0;
  localparam logic [3:0] IN_FIRST = 4'h1;
  localparam logic [3:0] IN_SECOND = 4'h2;
  localparam logic [3:0] IN_THIRD = 4'h4;
  localparam logic [3:0] IN_FOURTH = 4'h8;

  // values after reset
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [3:0] POS_RESET = IN_FIRST;
  localparam logic [3:0] NEG_RESET = IN_SECOND;

  // sequencer states
  typedef enum logic [2:0] {
    ADCS_IDLE = 3'b001,
    ADCS_CONV = 3'b010,
    ADCS_STORE = 3'b100
  } adcs_state_t;

  // modulator ticks in one conversion for a rate code (rounded down)
  function automatic logic [TICK_W-1:0] conv_ticks(input logic [2:0] code);
    logic [TICK_W-1:0] t;
    t = TICK_W'(MOD_HZ / RATE_SPS[0]);
    for (int i = 0; i < 8; i++) begin
      if (code == 3'(i)) begin
        t = TICK_W'(MOD_HZ / RATE_SPS[i]);
      end
    end
    return t;
  endfunction : conv_ticks

  // reciprocal of the tick count, scaled by two to the RECIP_SHIFT
  function automatic logic [RECIP_W-1:0] conv_recip(input logic [2:0] code);
    logic [RECIP_W-1:0] r;
    r = RECIP_W'((1 << RECIP_SHIFT) / (MOD_HZ / RATE_SPS[0]));
    for (int i = 0; i < 8; i++) begin
      if (code == 3'(i)) begin
        r = RECIP_W'((1 << RECIP_SHIFT) / (MOD_HZ / RATE_SPS[i]));
      end
    end
    return r;
  endfunction : conv_recip

endpackage : adcs_pkg

`default_nettype wire

// ==== hw/adcs_sequencer.sv ====
/*
  Conversion sequencer for a 12-bit delta-sigma converter: single-shot and
  continuous sequencing, input selection and the conversion result.
  Assumes the host controller drives the control inputs on CLOCK_IN and
  that the modulator bitstream arrives asynchronously on MOD_BIT_IN.
*/
// Overview of operation
// - single-shot does one conversion, stores result, then powers down.
// - continuous mode starts the next conversion right after the last one.
// - continuous conversions complete at the programmed data rate.
// - result output always readable, shows the latest completed conversion.
// - selector offers four single-ended inputs or two differential pairs.
// - selector also pairs first or second input against the fourth.
// - three-bit input select field picks the multiplexer setting.
// - single-ended selections tie the negative converter input to ground.
// - variant without multiplexer always converts first minus second input.
// - modulator rate is the 1 MHz oscillator divided by four.
// - filter turns the bitstream into a 12-bit code proportional to input.
// - three-bit rate field selects 128 to 3300 samples per second.
// - each conversion lasts one data-rate period, settling in one cycle.
`timescale 1ns/100ps
`default_nettype none

module adcs_sequencer #(
  parameter bit HAS_MUX = 1'b1,
  parameter int unsigned OSC_DIV = adcs_pkg::CLK_PER_OSC
) (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // host control
  input wire logic START_IN,
  input wire logic CONTINUOUS_IN,
  input wire logic [2:0] INPUT_SELECT_FIELD_IN,
  input wire logic [2:0] RATE_SELECT_FIELD_IN,
  // modulator bitstream
  input wire logic MOD_BIT_IN,
  // modulator control
  output logic MODULATOR_RATE_OUT,
  output logic MODULATOR_ENABLE_OUT,
  // input switches
  output logic [3:0] POS_SELECT_OUT,
  output logic [3:0] NEG_SELECT_OUT,
  output logic NEG_GROUND_OUT,
  // result and status
  output logic [11:0] RESULT_OUT,
  output logic RESULT_READY_OUT,
  output logic BUSY_OUT,
  output logic POWER_DOWN_OUT
);

  typedef struct packed {
    adcs_pkg::adcs_state_t st;
    logic [10:0] count;
    logic [2:0] rate;
    logic [3:0] pos;
    logic [3:0] neg;
    logic gnd;
    logic [11:0] result;
    logic ready;
    logic sync1;
    logic sync2;
  } adcs_seq_t;

  adcs_seq_t q;
  adcs_seq_t next_q;
  logic mod_tick;
  logic finish;
  logic latch_now;
  logic [10:0] ticks;
  logic [16:0] recip;
  logic [8:0] route;
  logic dec_done;
  logic [11:0] dec_code;

  // switch set for a selector code: {positive, negative, ground}
  function automatic logic [8:0] decode_select(input logic [2:0] sel, input logic mux);
    logic [8:0] r;
    r = {adcs_pkg::IN_FIRST, adcs_pkg::IN_SECOND, 1'b0};
    if (mux) begin
      case (sel)
        adcs_pkg::SEL_P0_N1: r = {adcs_pkg::IN_FIRST, adcs_pkg::IN_SECOND, 1'b0};
        adcs_pkg::SEL_P0_N3: r = {adcs_pkg::IN_FIRST, adcs_pkg::IN_FOURTH, 1'b0};
        adcs_pkg::SEL_P1_N3: r = {adcs_pkg::IN_SECOND, adcs_pkg::IN_FOURTH, 1'b0};
        adcs_pkg::SEL_P2_N3: r = {adcs_pkg::IN_THIRD, adcs_pkg::IN_FOURTH, 1'b0};
        adcs_pkg::SEL_SE_P0: r = {adcs_pkg::IN_FIRST, adcs_pkg::IN_NONE, 1'b1};
        adcs_pkg::SEL_SE_P1: r = {adcs_pkg::IN_SECOND, adcs_pkg::IN_NONE, 1'b1};
        adcs_pkg::SEL_SE_P2: r = {adcs_pkg::IN_THIRD, adcs_pkg::IN_NONE, 1'b1};
        adcs_pkg::SEL_SE_P3: r = {adcs_pkg::IN_FOURTH, adcs_pkg::IN_NONE, 1'b1};
        default: r = {adcs_pkg::IN_FIRST, adcs_pkg::IN_SECOND, 1'b0};
      endcase
    end
    return r;
  endfunction : decode_select

  // modulator rate enable, stopped in power-down
  adcs_mod_clock #(
    .OSC_DIV(OSC_DIV)
  ) u_mod_clock (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .en_in(MODULATOR_ENABLE_OUT),
    .mod_tick_out(mod_tick)
  );

  // bitstream filter, fed from the second synchroniser stage only
  adcs_decim_filter u_filter (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .clear_in(q.st == adcs_pkg::ADCS_IDLE),
    .tick_in(mod_tick && q.st == adcs_pkg::ADCS_CONV),
    .finish_in(finish),
    .bit_in(q.sync2),
    .ticks_in(ticks),
    .recip_in(recip),
    .code_out(dec_code),
    .done_out(dec_done)
  );

  // conversion length follows the rate latched at conversion start
  assign ticks = adcs_pkg::conv_ticks(q.rate);
  assign recip = adcs_pkg::conv_recip(q.rate);
  assign finish = mod_tick && q.st == adcs_pkg::ADCS_CONV && q.count == ticks - 11'h001;
  assign latch_now = q.st == adcs_pkg::ADCS_IDLE && (START_IN || CONTINUOUS_IN);
  assign route = decode_select(INPUT_SELECT_FIELD_IN, HAS_MUX);

  // sequencer; settings are sampled only at a conversion start, so a host
  // write mid-conversion takes effect on the next one and never tears it
  always_comb begin
    next_q = q;
    next_q.ready = 1'b0;
    next_q.sync1 = MOD_BIT_IN;
    next_q.sync2 = q.sync1;
    case (q.st)
      adcs_pkg::ADCS_IDLE: begin
        if (START_IN || CONTINUOUS_IN) begin
          next_q.st = adcs_pkg::ADCS_CONV;
          next_q.count = 11'h000;
          next_q.rate = RATE_SELECT_FIELD_IN;
          {next_q.pos, next_q.neg, next_q.gnd} = route;
        end
      end
      adcs_pkg::ADCS_CONV: begin
        if (finish) begin
          next_q.count = 11'h000;
          if (CONTINUOUS_IN) begin
            next_q.rate = RATE_SELECT_FIELD_IN;
            {next_q.pos, next_q.neg, next_q.gnd} = route;
          end else begin
            next_q.st = adcs_pkg::ADCS_STORE;
          end
        end else if (mod_tick) begin
          next_q.count = q.count + 11'h001;
        end
      end
      adcs_pkg::ADCS_STORE: begin
        if (dec_done) begin
          next_q.st = adcs_pkg::ADCS_IDLE;
        end
      end
      default: begin
        next_q.st = adcs_pkg::ADCS_IDLE;
      end
    endcase
    // whole word replaced in one edge
    if (dec_done) begin
      next_q.result = dec_code;
      next_q.ready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q.st <= adcs_pkg::ADCS_IDLE;
      q.count <= 11'h000;
      q.rate <= adcs_pkg::RATE_RESET;
      q.pos <= adcs_pkg::POS_RESET;
      q.neg <= adcs_pkg::NEG_RESET;
      q.gnd <= 1'b0;
      q.result <= adcs_pkg::RESULT_RESET;
      q.ready <= 1'b0;
      q.sync1 <= 1'b0;
      q.sync2 <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // outputs
  assign MODULATOR_RATE_OUT = mod_tick;
  assign MODULATOR_ENABLE_OUT = q.st != adcs_pkg::ADCS_IDLE;
  assign POS_SELECT_OUT = q.pos;
  assign NEG_SELECT_OUT = q.neg;
  assign NEG_GROUND_OUT = q.gnd;
  assign RESULT_OUT = q.result;
  assign RESULT_READY_OUT = q.ready;
  assign BUSY_OUT = q.st != adcs_pkg::ADCS_IDLE;
  assign POWER_DOWN_OUT = q.st == adcs_pkg::ADCS_IDLE;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);

  a_single_one_result: assert property (
    (finish && !CONTINUOUS_IN) |=> q.st == adcs_pkg::ADCS_STORE ##1 (RESULT_READY_OUT && POWER_DOWN_OUT))
    else $error("single-shot did not store and power down");

  a_cont_restart: assert property (
    (finish && CONTINUOUS_IN) |=> (q.st == adcs_pkg::ADCS_CONV && q.count == 11'h000))
    else $error("continuous mode did not restart");

  a_cont_ready: assert property (
    (finish && CONTINUOUS_IN) |=> ##1 (RESULT_READY_OUT && BUSY_OUT))
    else $error("continuous result not delivered");

  a_result_stable: assert property (
    !dec_done |=> $stable(RESULT_OUT))
    else $error("result changed without a completed conversion");

  a_result_load: assert property (
    dec_done |=> RESULT_OUT == $past(dec_code))
    else $error("result not loaded whole");

  a_rate_latch: assert property (
    latch_now |=> q.rate == $past(RATE_SELECT_FIELD_IN))
    else $error("rate field not taken at start");

  a_fourth_neg: assert property (
    (latch_now && HAS_MUX && INPUT_SELECT_FIELD_IN == adcs_pkg::SEL_P1_N3)
      |=> (POS_SELECT_OUT == adcs_pkg::IN_SECOND && NEG_SELECT_OUT == adcs_pkg::IN_FOURTH))
    else $error("second against fourth pairing wrong");

  a_se_ground: assert property (
    (latch_now && HAS_MUX && INPUT_SELECT_FIELD_IN[adcs_pkg::SEL_SE_BIT])
      |=> (NEG_GROUND_OUT && NEG_SELECT_OUT == adcs_pkg::IN_NONE))
    else $error("single-ended input not grounded");

  a_fixed_pair: assert property (
    !HAS_MUX |-> (POS_SELECT_OUT == adcs_pkg::IN_FIRST && NEG_SELECT_OUT == adcs_pkg::IN_SECOND
      && !NEG_GROUND_OUT))
    else $error("fixed pair not selected");

  a_start_busy: assert property (
    latch_now |=> (BUSY_OUT && MODULATOR_ENABLE_OUT))
    else $error("start did not raise busy");

  // differential codes keep the negative input on a pin, never on ground
  a_diff_no_ground: assert property (
    (latch_now && HAS_MUX && !INPUT_SELECT_FIELD_IN[adcs_pkg::SEL_SE_BIT])
      |=> !NEG_GROUND_OUT)
    else $error("differential input grounded");

  // the first input against the fourth is the other pairing on a shared negative pin
  a_first_fourth: assert property (
    (latch_now && HAS_MUX && INPUT_SELECT_FIELD_IN == adcs_pkg::SEL_P0_N3)
      |=> (POS_SELECT_OUT == adcs_pkg::IN_FIRST && NEG_SELECT_OUT == adcs_pkg::IN_FOURTH))
    else $error("first against fourth pairing wrong");

  // a converter input switched to two pins at once would short them together
  a_pos_onehot: assert property (
    BUSY_OUT |-> $onehot(POS_SELECT_OUT))
    else $error("positive switch set not one-hot");

  // switches move only at a conversion start, never inside a conversion
  a_switch_hold: assert property (
    !(latch_now || finish)
      |=> ($stable(POS_SELECT_OUT) && $stable(NEG_SELECT_OUT) && $stable(NEG_GROUND_OUT)))
    else $error("input switches moved mid-conversion");

  // a rate write during a conversion must not stretch or cut it
  a_rate_hold: assert property (
    !(latch_now || finish) |=> $stable(q.rate))
    else $error("rate changed mid-conversion");

  // continuous mode takes the rate field afresh for every conversion
  a_cont_rate: assert property (
    (finish && CONTINUOUS_IN) |=> q.rate == $past(RATE_SELECT_FIELD_IN))
    else $error("continuous rate not resampled");

  // the tick counter never passes the end of a conversion
  a_count_range: assert property (
    q.st == adcs_pkg::ADCS_CONV |-> q.count < ticks)
    else $error("tick count beyond conversion length");

  // one count per modulator tick, so the length is ticks times the tick period
  a_count_step: assert property (
    (mod_tick && q.st == adcs_pkg::ADCS_CONV && !finish)
      |=> q.count == $past(q.count) + 11'h001)
    else $error("tick count did not advance");

  // the ready pulse is only ever the echo of a filter result
  a_ready_cause: assert property (
    RESULT_READY_OUT |-> $past(dec_done))
    else $error("ready without a stored result");

  // with no request pending the block stays powered down
  a_stay_down: assert property (
    (POWER_DOWN_OUT && !START_IN && !CONTINUOUS_IN) |=> POWER_DOWN_OUT)
    else $error("left power-down without a request");

  // power-down must really stop the modulator, not only flag it
  a_down_quiet: assert property (
    POWER_DOWN_OUT |-> (!MODULATOR_ENABLE_OUT && !BUSY_OUT))
    else $error("modulator running in power-down");

endmodule : adcs_sequencer

`default_nettype wire

// ==== testbench/adcs_host_model.sv ====
/*
  Host controller and bitstream source that face the conversion sequencer.
  Assumes the bench calls its tasks and that the sequencer's modulator tick
  arrives on tick_in; every output changes on the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module adcs_host_model (
  // clock and modulator tick
  input wire logic clk_in,
  input wire logic tick_in,
  // control towards the sequencer
  output logic start_out,
  output logic cont_out,
  output logic [2:0] sel_out,
  output logic [2:0] rate_out,
  // modulator bitstream
  output logic bit_out
);
  logic [1:0] pattern;

  // quiet bus until the first request
  initial begin
    start_out = 1'b0;
    cont_out = 1'b0;
    sel_out = 3'h0;
    rate_out = 3'h6;
    bit_out = 1'b0;
    pattern = 2'h0;
  end

  // bitstream; half pattern flips only on ticks so ones and zeros balance
  always @(negedge clk_in) begin
    if (pattern == 2'h2) begin
      if (tick_in) bit_out <= ~bit_out;
    end else begin
      bit_out <= pattern[0];
    end
  end

  // one request: fields with a one-cycle start, or continuous level
  task automatic request(input logic [2:0] sel, input logic [2:0] rate, input logic cont);
    @(negedge clk_in);
    sel_out = sel;
    rate_out = rate;
    cont_out = cont;
    start_out = ~cont;
    @(negedge clk_in);
    start_out = 1'b0;
  endtask : request

  // level change of the continuous control
  task automatic set_cont(input logic cont);
    @(negedge clk_in);
    cont_out = cont;
  endtask : set_cont
endmodule : adcs_host_model

`default_nettype wire

// ==== testbench/testbench.sv ====
/*
  Self-checking bench for the conversion sequencer, with a shortened
  oscillator divider (tick every 8 clocks) and a mux-less twin.
  Assumes the host model drives all control and bitstream inputs.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module testbench;
  localparam int unsigned DIV = 2;
  localparam int unsigned TP = 4 * DIV;
  localparam int NT [8] = '{1953, 1000, 510, 271, 156, 104, 75, 75};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start, cont, mbit, mtick, men, gnd, rdy, busy, pdn, gnd2;
  logic [2:0] sel, rate;
  logic [3:0] pos, neg, pos2, neg2;
  logic [11:0] res;
  int err_count = 0;
  int checks = 0;
  int cyc, nt, bad;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  adcs_host_model host (.clk_in(clock), .tick_in(mtick), .start_out(start),
    .cont_out(cont), .sel_out(sel), .rate_out(rate), .bit_out(mbit));

  adcs_sequencer #(.HAS_MUX(1'b1), .OSC_DIV(DIV)) dut (.CLOCK_IN(clock), .RST_IN(rst),
    .START_IN(start), .CONTINUOUS_IN(cont), .INPUT_SELECT_FIELD_IN(sel),
    .RATE_SELECT_FIELD_IN(rate), .MOD_BIT_IN(mbit), .MODULATOR_RATE_OUT(mtick),
    .MODULATOR_ENABLE_OUT(men), .POS_SELECT_OUT(pos), .NEG_SELECT_OUT(neg),
    .NEG_GROUND_OUT(gnd), .RESULT_OUT(res), .RESULT_READY_OUT(rdy),
    .BUSY_OUT(busy), .POWER_DOWN_OUT(pdn));

  // twin without a multiplexer; only its switch outputs are judged
  adcs_sequencer #(.HAS_MUX(1'b0), .OSC_DIV(DIV)) dut2 (.CLOCK_IN(clock), .RST_IN(rst),
    .START_IN(start), .CONTINUOUS_IN(cont), .INPUT_SELECT_FIELD_IN(sel),
    .RATE_SELECT_FIELD_IN(rate), .MOD_BIT_IN(mbit), .MODULATOR_RATE_OUT(),
    .MODULATOR_ENABLE_OUT(), .POS_SELECT_OUT(pos2), .NEG_SELECT_OUT(neg2),
    .NEG_GROUND_OUT(gnd2), .RESULT_OUT(), .RESULT_READY_OUT(), .BUSY_OUT(),
    .POWER_DOWN_OUT());

  // waits for the next ready pulse, stepping one edge first so a pulse in view is skipped
  task automatic conv_wait();
    logic [11:0] r0;
    r0 = res;
    cyc = 0;
    nt = 0;
    bad = 0;
    do begin
      @(posedge clock);
      #1;
      cyc++;
      if (mtick === 1'b1) nt++;
      if (rdy !== 1'b1 && (res !== r0 || busy !== 1'b1)) bad++;
    end while (rdy !== 1'b1 && cyc < 20000);
    `CHK("ready seen", 1'b1, rdy)
    `CHK("no early change", 0, bad)
  endtask : conv_wait

  task automatic t_reset();
    `CHK("reset result", 12'h000, res)
    `CHK("reset pdn", 1'b1, pdn)
    `CHK("reset pos", 4'h1, pos)
    `CHK("reset neg", 4'h2, neg)
  endtask : t_reset

  // one shot at full positive input, then powered down
  task automatic t_single();
    host.pattern = 2'h1;
    host.request(3'h0, 3'h6, 1'b0);
    conv_wait();
    `CHK("full code", 12'h7ff, res)
    `CHK("ticks", 75, nt)
    `CHK("length", 1'b1, cyc >= 75 * TP && cyc <= 75 * TP + 4)
    @(negedge clock);
    `CHK("pdn after", 1'b1, pdn)
    `CHK("idle busy", 1'b0, busy)
    `CHK("mod off", 1'b0, men)
  endtask : t_single

  // every selector code on both variants
  task automatic t_mux();
    logic [3:0] ep, en;
    host.pattern = 2'h0;
    for (int c = 0; c < 8; c++) begin
      ep = (c >= 4) ? 4'h1 << (c - 4) : (c == 0 ? 4'h1 : 4'h1 << (c - 1));
      en = (c >= 4) ? 4'h0 : (c == 0 ? 4'h2 : 4'h8);
      host.request(3'(c), 3'h6, 1'b0);
      conv_wait();
      `CHK("pos", ep, pos)
      `CHK("neg", en, neg)
      `CHK("gnd", c >= 4, gnd)
      `CHK("fixed pos", 4'h1, pos2)
      `CHK("fixed neg", 4'h2, neg2)
      `CHK("fixed gnd", 1'b0, gnd2)
    end
    `CHK("zero code", 12'h800, res)
  endtask : t_mux

  // every data rate code sets the conversion length
  task automatic t_rates();
    for (int r = 0; r < 8; r++) begin
      host.request(3'h0, 3'(r), 1'b0);
      conv_wait();
      `CHK("rate ticks", NT[r], nt)
      `CHK("rate len", 1'b1, cyc >= NT[r] * TP && cyc <= NT[r] * TP + 4)
    end
  endtask : t_rates

  // continuous run at 2400 samples per second, then back to single
  task automatic t_cont();
    host.pattern = 2'h2;
    host.request(3'h1, 3'h5, 1'b1);
    conv_wait();
    conv_wait();
    `CHK("period", 104 * TP, cyc)
    `CHK("half code", 1'b1, $signed(res) > -64 && $signed(res) < 64)
    `CHK("still busy", 1'b1, busy)
    host.set_cont(1'b0);
    conv_wait();
    repeat (3) @(negedge clock);
    `CHK("stopped", 1'b0, busy)
  endtask : t_cont

  // a start while busy is ignored; the wait opens 102 clocks in, twelve ticks gone
  task automatic t_refuse();
    host.request(3'h4, 3'h6, 1'b0);
    repeat (100) @(negedge clock);
    host.request(3'h7, 3'h0, 1'b0);
    conv_wait();
    `CHK("kept pos", 4'h1, pos)
    `CHK("kept len", 75 - 12, nt)
    `CHK("kept end", 75 * TP + 2 - 102, cyc)
    repeat (20) @(negedge clock);
    `CHK("no rerun", 1'b0, busy)
  endtask : t_refuse

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_single();
    t_mux();
    t_rates();
    t_cont();
    t_refuse();
    report_and_stop();
  end

  // watchdog well beyond the roughly 42k cycles the scenarios need
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
